// ### rtl/dcmm_pkg.sv
// Constants, register map and carrier types of the drive channel mapping monitor.
//
// Functional notes
// [RL1] PWM channels 4-9 use hard-wired speed inputs.
// [RL2] Override zero keeps the default speed input.
// [RL3] Channels 0,2 take 15/17; 1,3 take 16/18.
// [RL4] Illegal override raises encoder-input error with axis.
// [RL5] Position inputs route freely within each board.
// [RL6] Channels 0-3 single-speed, 4-9 double-speed.
// [RL7] One processor per two single or one double loop.
// [RL8] Single 200/200/100 us, double 200/100/100 us.
// [RL9] PWM rate fixed at 5 kHz on all axes.
// [RL10] Position cycle equals one PWM period.
// [RL11] PLC cycle 0-60 ms; 0-10 gives 10.8 ms.
// [RL12] Bits 4/5 disable over/under temperature checks.
// [RL13] Bit 7 clear checks encoder frequency, errors 8860/8870.
// [RL14] Encoderless axis ramps gain on reclose; bit 8 disables.
// [RL15] Errors latch with axis until software acknowledges.
package dcmm_pkg;

    // Register byte offsets on the Avalon slave.
    localparam logic [5:0] OFS_MON_CTL   = 6'h00;
    localparam logic [5:0] OFS_PLC_CYC   = 6'h04;
    localparam logic [5:0] OFS_SPD_OVR   = 6'h08;
    localparam logic [5:0] OFS_POS_LO    = 6'h0C;
    localparam logic [5:0] OFS_POS_HI    = 6'h10;
    localparam logic [5:0] OFS_AXIS_LO   = 6'h14;
    localparam logic [5:0] OFS_AXIS_HI   = 6'h18;
    localparam logic [5:0] OFS_NO_PENC   = 6'h1C;
    localparam logic [5:0] OFS_ERR_STAT  = 6'h20;
    localparam logic [5:0] OFS_LOOP_STAT = 6'h24;

    // Field positions.
    localparam int BIT_OVT_OFF   = 4;
    localparam int BIT_UVT_OFF   = 5;
    localparam int BIT_FREQ_OFF  = 7;
    localparam int BIT_RAMP_OFF  = 8;
    localparam int BIT_ERR_VALID = 24;
    localparam int BIT_ERR_MORE  = 25;

    // Reset values.
    localparam logic [8:0]  RST_MON_CTL = 9'h000;
    localparam logic [7:0]  RST_PLC_CYC = 8'h00;
    localparam logic [31:0] RST_SPD_OVR = 32'h0000_0000;
    localparam logic [17:0] RST_POS_LO  = 18'h2C688;
    localparam logic [7:0]  RST_POS_HI  = 8'hE4;
    localparam logic [9:0]  RST_AXES    = 10'h000;

    // Error codes.
    localparam logic [15:0] ERR_ENC_INPUT = 16'hC2A0;
    localparam logic [15:0] ERR_SPD_FREQ  = 16'h8860;
    localparam logic [15:0] ERR_POS_FREQ  = 16'h8870;
    localparam logic [15:0] ERR_OVER_TEMP = 16'h0E01;
    localparam logic [15:0] ERR_UNDR_TEMP = 16'h0E02;

    // Loop classes and processor assignment per channel.
    localparam logic [9:0]  DOUBLE_SPEED_MASK = 10'h3F0;
    localparam logic [39:0] DSP_TABLE = 40'h7654_3211_00;

    // Timing at the 100 MHz system clock.
    localparam int CLK_PERIOD_NS   = 10;
    localparam int PWM_PERIOD_NS   = 200000;
    localparam int PWM_CYC         = PWM_PERIOD_NS / CLK_PERIOD_NS;
    localparam int MS_NS           = 1000000;
    localparam int CYC_PER_MS      = MS_NS / CLK_PERIOD_NS;
    localparam int PLC_MIN_NS      = 10800000;
    localparam int PLC_MIN_CYC     = PLC_MIN_NS / CLK_PERIOD_NS;
    localparam logic [7:0] PLC_FLOOR_MS = 8'h0A;
    localparam logic [7:0] PLC_MAX_MS   = 8'h3C;
    localparam logic [7:0] KV_FULL      = 8'hFF;
    localparam logic [7:0] KV_STEP      = 8'h01;

    // Monitor pins, one bit per channel or per encoder input.
    typedef struct packed {
        logic [9:0] over_temp;
        logic [9:0] under_temp;
        logic [9:0] spd_freq_fault;
        logic [9:0] pos_freq_fault;
        logic [9:0] loop_closed;
    } dcmm_mon_s;

    // Latched error indication.
    typedef struct packed {
        logic        more;
        logic        valid;
        logic [3:0]  axis;
        logic [15:0] code;
    } dcmm_err_s;

endpackage

// ### rtl/dcmm_top.sv
// Drive channel mapping, loop timing and monitoring with an Avalon-MM register slave.
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dcmm_top #(
    parameter int PWM_CYC     = dcmm_pkg::PWM_CYC,
    parameter int CYC_PER_MS  = dcmm_pkg::CYC_PER_MS,
    parameter int PLC_MIN_CYC = dcmm_pkg::PLC_MIN_CYC
) (
    input  wire logic               clk_sys,
    input  wire logic               reset,
    input  wire logic [5:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic      [31:0]        avs_readdata,
    output logic                    avs_waitrequest,
    input  wire dcmm_pkg::dcmm_mon_s mon_raw,
    output logic      [39:0]        spd_route_q,
    output logic      [39:0]        pos_route_q,
    output logic                    pwm_tick_q,
    output logic                    cur_tick_q,
    output logic                    pos_tick_q,
    output logic      [9:0]         spd_tick_q,
    output logic                    plc_tick_q,
    output logic      [79:0]        kv_scale_q,
    output dcmm_pkg::dcmm_err_s     err_q
);

    logic [8:0]  mon_ctl_q;
    logic [7:0]  plc_cyc_q;
    logic [31:0] spd_ovr_q;
    logic [17:0] pos_lo_q;
    logic [7:0]  pos_hi_q;
    logic [9:0]  axis_en_q;
    logic [9:0]  no_penc_q;
    logic        wr_ack_q;
    dcmm_pkg::dcmm_mon_s mon_s1_q;
    dcmm_pkg::dcmm_mon_s mon_s2_q;
    logic [9:0]  closed_d1_q;
    logic [9:0]  ramp_act_q;
    logic [14:0] pwm_cnt_q;
    logic [22:0] plc_cnt_q;
    logic [22:0] plc_len;
    logic [39:0] spd_route_d;
    logic [39:0] pos_route_d;
    logic [9:0]  bad_ovr;
    logic [9:0]  bad_pos;
    logic [9:0]  ovt_err;
    logic [9:0]  uvt_err;
    logic [9:0]  sfq_err;
    logic [9:0]  pfq_err;
    logic        new_err;
    dcmm_pkg::dcmm_err_s err_d;
    logic        bus_req;
    logic        bus_wr;
    logic        err_ack;
    logic [31:0] rd_mux;

    // Merges write data into a register under the byte enables.
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // A request is answered one cycle after it is seen; waitrequest drops for that cycle.
    assign bus_req = (avs_read | avs_write) & ~wr_ack_q;
    assign bus_wr  = avs_write & wr_ack_q;
    assign err_ack = bus_wr && avs_address == dcmm_pkg::OFS_ERR_STAT
                     && avs_byteenable[3] && avs_writedata[dcmm_pkg::BIT_ERR_VALID];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_ack_q        <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            wr_ack_q        <= bus_req;
            avs_waitrequest <= ~bus_req;
        end
    end

    // Read multiplexer; unmapped offsets read as zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address)
            dcmm_pkg::OFS_MON_CTL:   rd_mux[8:0]  = mon_ctl_q;
            dcmm_pkg::OFS_PLC_CYC:   rd_mux[7:0]  = plc_cyc_q;
            dcmm_pkg::OFS_SPD_OVR:   rd_mux       = spd_ovr_q;
            dcmm_pkg::OFS_POS_LO:    rd_mux[17:0] = pos_lo_q;
            dcmm_pkg::OFS_POS_HI:    rd_mux[7:0]  = pos_hi_q;
            dcmm_pkg::OFS_AXIS_LO:   rd_mux[5:0]  = axis_en_q[5:0];
            dcmm_pkg::OFS_AXIS_HI:   rd_mux[3:0]  = axis_en_q[9:6];
            dcmm_pkg::OFS_NO_PENC:   rd_mux[9:0]  = no_penc_q;
            dcmm_pkg::OFS_ERR_STAT: begin
                rd_mux[15:0]                    = err_q.code;
                rd_mux[19:16]                   = err_q.axis;
                rd_mux[dcmm_pkg::BIT_ERR_VALID] = err_q.valid;
                rd_mux[dcmm_pkg::BIT_ERR_MORE]  = err_q.more;
            end
            dcmm_pkg::OFS_LOOP_STAT: rd_mux = {6'h00, ramp_act_q, 6'h00, dcmm_pkg::DOUBLE_SPEED_MASK};
            default:                 rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is captured when the request is accepted and stands in the answer cycle.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
        end else if (bus_req && avs_read) begin
            avs_readdata <= rd_mux;
        end
    end

    // Configuration registers written by software.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mon_ctl_q <= dcmm_pkg::RST_MON_CTL;
            plc_cyc_q <= dcmm_pkg::RST_PLC_CYC;
            spd_ovr_q <= dcmm_pkg::RST_SPD_OVR;
            pos_lo_q  <= dcmm_pkg::RST_POS_LO;
            pos_hi_q  <= dcmm_pkg::RST_POS_HI;
            axis_en_q <= dcmm_pkg::RST_AXES;
            no_penc_q <= dcmm_pkg::RST_AXES;
        end else if (bus_wr) begin
            unique case (avs_address)
                dcmm_pkg::OFS_MON_CTL: begin
                    mon_ctl_q <= 9'(be_merge({23'h0, mon_ctl_q}, avs_writedata, avs_byteenable));
                end
                dcmm_pkg::OFS_PLC_CYC: begin
                    plc_cyc_q <= 8'(be_merge({24'h0, plc_cyc_q}, avs_writedata, avs_byteenable));
                end
                dcmm_pkg::OFS_SPD_OVR: begin
                    spd_ovr_q <= be_merge(spd_ovr_q, avs_writedata, avs_byteenable);
                end
                dcmm_pkg::OFS_POS_LO: begin
                    pos_lo_q <= 18'(be_merge({14'h0, pos_lo_q}, avs_writedata, avs_byteenable));
                end
                dcmm_pkg::OFS_POS_HI: begin
                    pos_hi_q <= 8'(be_merge({24'h0, pos_hi_q}, avs_writedata, avs_byteenable));
                end
                dcmm_pkg::OFS_AXIS_LO: begin
                    axis_en_q[5:0] <= 6'(be_merge({26'h0, axis_en_q[5:0]}, avs_writedata,
                                                  avs_byteenable));
                end
                dcmm_pkg::OFS_AXIS_HI: begin
                    axis_en_q[9:6] <= 4'(be_merge({28'h0, axis_en_q[9:6]}, avs_writedata,
                                                  avs_byteenable));
                end
                dcmm_pkg::OFS_NO_PENC: begin
                    no_penc_q <= 10'(be_merge({22'h0, no_penc_q}, avs_writedata, avs_byteenable));
                end
                default: begin
                end
            endcase
        end
    end

    // Two-stage synchroniser for the monitor pins.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mon_s1_q <= '0;
            mon_s2_q <= '0;
        end else begin
            mon_s1_q <= mon_raw;
            mon_s2_q <= mon_s1_q;
        end
    end

    // Per-channel routing and error detection.
    for (genvar ch = 0; ch < 10; ch++) begin : g_ch
        logic [4:0] ovr;
        logic [3:0] pidx;
        logic [3:0] spd_sel;
        logic       ovr_bad;
        logic       ramp_q;
        logic [7:0] kv_q;
        // Only channels 0-3 own an override byte; the others never switch inputs.
        if (ch < 4) begin : g_ovr
            assign ovr = spd_ovr_q[8*ch +: 5];
        end else begin : g_no_ovr
            assign ovr = 5'h00;
        end
        if (ch < 6) begin : g_lo
            assign pidx = {1'b0, pos_lo_q[3*ch +: 3]}; // RL5
        end else begin : g_hi
            assign pidx = 4'(6 + pos_hi_q[2*(ch-6) +: 2]); // RL5
        end
        // Default input is the channel's own; channels 0-3 may switch spindle inputs.
        always_comb begin
            spd_sel = 4'(ch); // RL1 RL2
            ovr_bad = 1'b0;
            if (ovr != 5'h00) begin
                if ((ch % 2 == 0) && (ovr == 5'h0F || ovr == 5'h11)) begin
                    spd_sel = (ovr == 5'h0F) ? 4'h0 : 4'h2; // RL3
                end else if ((ch % 2 == 1) && (ovr == 5'h10 || ovr == 5'h12)) begin
                    spd_sel = (ovr == 5'h10) ? 4'h1 : 4'h3; // RL3
                end else begin
                    ovr_bad = axis_en_q[ch]; // RL4
                end
            end
        end
        assign spd_route_d[4*ch +: 4] = spd_sel;
        assign bad_ovr[ch]            = ovr_bad;
        assign pos_route_d[4*ch +: 4] = (pidx > 4'h5 && ch < 6) ? 4'(ch) : pidx;
        assign bad_pos[ch] = axis_en_q[ch] && ch < 6 && pidx > 4'h5;
        assign ovt_err[ch] = axis_en_q[ch] && !mon_ctl_q[dcmm_pkg::BIT_OVT_OFF]
                             && mon_s2_q.over_temp[ch]; // RL12
        assign uvt_err[ch] = axis_en_q[ch] && !mon_ctl_q[dcmm_pkg::BIT_UVT_OFF]
                             && mon_s2_q.under_temp[ch]; // RL12
        assign sfq_err[ch] = axis_en_q[ch] && !mon_ctl_q[dcmm_pkg::BIT_FREQ_OFF]
                             && mon_s2_q.spd_freq_fault[spd_route_q[4*ch +: 4]]; // RL13
        assign pfq_err[ch] = axis_en_q[ch] && !mon_ctl_q[dcmm_pkg::BIT_FREQ_OFF]
                             && mon_s2_q.pos_freq_fault[pos_route_q[4*ch +: 4]]; // RL13

        // Gain ramp for an encoderless axis that is closed again; full gain for other closed loops, zero while the loop is open.
        always_ff @(posedge clk_sys) begin
            if (reset) begin
                ramp_q <= 1'b0;
                kv_q   <= 8'h00;
            end else if (!mon_s2_q.loop_closed[ch]) begin
                ramp_q <= 1'b0;
                kv_q   <= 8'h00;
            end else if (!closed_d1_q[ch]) begin
                if (no_penc_q[ch] && !mon_ctl_q[dcmm_pkg::BIT_RAMP_OFF]) begin
                    ramp_q <= 1'b1; // RL14
                    kv_q   <= 8'h00; // RL14
                end else begin
                    kv_q <= dcmm_pkg::KV_FULL;
                end
            end else if (ramp_q && pos_tick_q) begin
                kv_q <= kv_q + dcmm_pkg::KV_STEP; // RL14
                if (kv_q == dcmm_pkg::KV_FULL - dcmm_pkg::KV_STEP) begin
                    ramp_q <= 1'b0;
                end
            end
        end
        assign ramp_act_q[ch]        = ramp_q;
        assign kv_scale_q[8*ch +: 8] = kv_q;
    end

    // Registered routes and loop-close history.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            spd_route_q <= 40'h98_7654_3210;
            pos_route_q <= 40'h98_7654_3210;
            closed_d1_q <= 10'h000;
        end else begin
            spd_route_q <= spd_route_d; // RL1
            pos_route_q <= pos_route_d; // RL5
            closed_d1_q <= mon_s2_q.loop_closed;
        end
    end

    // Fixed 5 kHz PWM period; current every half period, position every period.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pwm_cnt_q  <= 15'h0000;
            pwm_tick_q <= 1'b0;
            pos_tick_q <= 1'b0;
            cur_tick_q <= 1'b0;
            spd_tick_q <= 10'h000;
        end else begin
            pwm_cnt_q  <= (pwm_cnt_q == 15'(PWM_CYC - 1)) ? 15'h0000 : pwm_cnt_q + 15'h0001; // RL9
            pwm_tick_q <= pwm_cnt_q == 15'(PWM_CYC - 1); // RL9
            pos_tick_q <= pwm_cnt_q == 15'(PWM_CYC - 1); // RL10 RL8
            cur_tick_q <= pwm_cnt_q == 15'(PWM_CYC - 1) || pwm_cnt_q == 15'(PWM_CYC / 2 - 1); // RL8
            spd_tick_q <= {{6{pwm_cnt_q == 15'(PWM_CYC - 1)
                            || pwm_cnt_q == 15'(PWM_CYC / 2 - 1)}},
                           {4{pwm_cnt_q == 15'(PWM_CYC - 1)}}}; // RL6 RL7 RL8
        end
    end

    // PLC cycle length in clock cycles, with a floor of 10.8 ms and a ceiling of 60 ms.
    always_comb begin
        if (plc_cyc_q <= dcmm_pkg::PLC_FLOOR_MS) begin
            plc_len = 23'(PLC_MIN_CYC); // RL11
        end else if (plc_cyc_q >= dcmm_pkg::PLC_MAX_MS) begin
            plc_len = 23'(CYC_PER_MS * 60); // RL11
        end else begin
            plc_len = 23'(CYC_PER_MS * int'(plc_cyc_q)); // RL11
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            plc_cnt_q  <= 23'h000000;
            plc_tick_q <= 1'b0;
        end else begin
            plc_cnt_q  <= (plc_cnt_q >= plc_len - 23'h000001) ? 23'h000000 : plc_cnt_q + 23'h000001;
            plc_tick_q <= plc_cnt_q >= plc_len - 23'h000001; // RL11
        end
    end

    // Lowest channel wins; class order is input, frequency, temperature.
    always_comb begin
        err_d = '0;
        for (int c = 9; c >= 0; c--) begin
            if (uvt_err[c]) begin
                err_d = '{more: 1'b0, valid: 1'b1, axis: 4'(c), code: dcmm_pkg::ERR_UNDR_TEMP};
            end
            if (ovt_err[c]) begin
                err_d = '{more: 1'b0, valid: 1'b1, axis: 4'(c), code: dcmm_pkg::ERR_OVER_TEMP};
            end
            if (pfq_err[c]) begin
                err_d = '{more: 1'b0, valid: 1'b1, axis: 4'(c), code: dcmm_pkg::ERR_POS_FREQ};
            end
            if (sfq_err[c]) begin
                err_d = '{more: 1'b0, valid: 1'b1, axis: 4'(c), code: dcmm_pkg::ERR_SPD_FREQ};
            end
            if (bad_ovr[c] || bad_pos[c]) begin
                err_d = '{more: 1'b0, valid: 1'b1, axis: 4'(c), code: dcmm_pkg::ERR_ENC_INPUT};
            end
        end
    end
    assign new_err = err_d.valid;

    // Error latch; a new error in the acknowledge cycle is kept.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            err_q <= '0;
        end else if (new_err && (!err_q.valid || err_ack)) begin
            err_q <= err_d; // RL15 RL4 RL13
        end else if (err_ack) begin
            err_q <= '0; // RL15
        end else if (new_err) begin
            err_q.more <= 1'b1; // RL15
        end
    end

    // Assertions.
    property p_default_route;
        @(posedge clk_sys) disable iff (reset) spd_ovr_q[4:0] == 5'h00 |=> spd_route_q[3:0] == 4'h0;
    endproperty
    a_default_route: assert property (p_default_route) else $error("default speed input lost"); // RL2

    property p_fixed_route;
        @(posedge clk_sys) disable iff (reset) ##1 spd_route_q[39:16] == 24'h98_7654;
    endproperty
    a_fixed_route: assert property (p_fixed_route) else $error("fixed speed input moved"); // RL1

    property p_alt_route;
        @(posedge clk_sys) disable iff (reset) spd_ovr_q[4:0] == 5'h11 |=> spd_route_q[3:0] == 4'h2;
    endproperty
    a_alt_route: assert property (p_alt_route) else $error("alternate input 17 not used"); // RL3

    property p_bad_ovr;
        @(posedge clk_sys) disable iff (reset)
            bad_ovr[1] && !bad_ovr[0] && !err_q.valid && !bad_pos[0]
            |=> err_q.valid && err_q.code == dcmm_pkg::ERR_ENC_INPUT;
    endproperty
    a_bad_ovr: assert property (p_bad_ovr) else $error("bad override not flagged"); // RL4

    property p_pos_route;
        @(posedge clk_sys) disable iff (reset) pos_hi_q[1:0] == 2'h3 |=> pos_route_q[27:24] == 4'h9;
    endproperty
    a_pos_route: assert property (p_pos_route) else $error("position route wrong"); // RL5

    property p_loop_class;
        @(posedge clk_sys) disable iff (reset)
            cur_tick_q |-> spd_tick_q[9:4] == 6'h3F && spd_tick_q[3:0] == {4{pos_tick_q}};
    endproperty
    a_loop_class: assert property (p_loop_class) else $error("loop class tick wrong"); // RL6

    property p_pos_tick;
        @(posedge clk_sys) disable iff (reset) pos_tick_q |-> cur_tick_q && pwm_tick_q && pwm_cnt_q == 15'h0000;
    endproperty
    a_pos_tick: assert property (p_pos_tick) else $error("position tick off PWM period"); // RL10

    property p_pwm_range;
        @(posedge clk_sys) disable iff (reset) pwm_cnt_q < 15'(PWM_CYC);
    endproperty
    a_pwm_range: assert property (p_pwm_range) else $error("PWM counter out of range"); // RL9

    property p_freq_off;
        @(posedge clk_sys) disable iff (reset)
            $rose(err_q.valid) && err_q.code == dcmm_pkg::ERR_SPD_FREQ
            |-> !$past(mon_ctl_q[dcmm_pkg::BIT_FREQ_OFF]);
    endproperty
    a_freq_off: assert property (p_freq_off) else $error("frequency error while disabled"); // RL13

    property p_temp_off;
        @(posedge clk_sys) disable iff (reset)
            $rose(err_q.valid) && err_q.code == dcmm_pkg::ERR_OVER_TEMP
            |-> !$past(mon_ctl_q[dcmm_pkg::BIT_OVT_OFF]);
    endproperty
    a_temp_off: assert property (p_temp_off) else $error("temperature error while disabled"); // RL12

    property p_ramp_start;
        @(posedge clk_sys) disable iff (reset) $rose(ramp_act_q[4]) |-> kv_scale_q[39:32] == 8'h00;
    endproperty
    a_ramp_start: assert property (p_ramp_start) else $error("ramp did not start at zero"); // RL14

    property p_err_hold;
        @(posedge clk_sys) disable iff (reset)
            err_q.valid && !err_ack |=> err_q.valid && $stable(err_q.code) && $stable(err_q.axis);
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error indication not held"); // RL15

    property p_plc_tick;
        @(posedge clk_sys) disable iff (reset)
            plc_tick_q |-> plc_cnt_q == 23'h000000
                           && $past(plc_cnt_q) >= $past(plc_len) - 23'h000001;
    endproperty
    a_plc_tick: assert property (p_plc_tick) else $error("PLC tick off cycle end"); // RL11

    c_bad_ovr:  cover property (@(posedge clk_sys) disable iff (reset) $rose(err_q.valid) && err_q.code == dcmm_pkg::ERR_ENC_INPUT);
    c_ramp_end: cover property (@(posedge clk_sys) disable iff (reset) $fell(ramp_act_q[4]));
    c_err_ack:  cover property (@(posedge clk_sys) disable iff (reset) err_ack && new_err);
    c_plc_tick: cover property (@(posedge clk_sys) disable iff (reset) plc_tick_q);

endmodule
`default_nettype wire

// ### verif/dcmm_drive_model.sv
// Power module and encoder side model that drives the monitor pins.
`timescale 1ns/1ps
`default_nettype none
module dcmm_drive_model (
    input  wire logic          clk_sys,
    input  wire logic [49:0]   fault_pat,
    output dcmm_pkg::dcmm_mon_s mon_raw
);
    // Pin levels follow fault_pat one clock later and change on the rising edge, in step with the bench.
    always_ff @(posedge clk_sys) begin
        mon_raw <= fault_pat;
    end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench of the drive channel mapping monitor.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                clk_sys = 1'b0;
    logic                reset   = 1'b1;
    logic [5:0]          adr     = 6'h00;
    logic                rd      = 1'b0;
    logic                wr      = 1'b0;
    logic [31:0]         wd      = 32'h0;
    logic [3:0]          be      = 4'hF;
    logic [49:0]         pat     = 50'h0;
    logic [31:0]         rdat;
    logic                wreq;
    logic [31:0]         q;
    dcmm_pkg::dcmm_mon_s mon;
    logic [39:0]         spd_r;
    logic [39:0]         pos_r;
    logic                pwm_t;
    logic                cur_t;
    logic                pos_t;
    logic [9:0]          spd_t;
    logic                plc_t;
    logic [79:0]         kv;
    dcmm_pkg::dcmm_err_s err;
    int                  err_total = 0;
    int                  checked   = 0;
    int                  n [5];
    int                  k;

    // The clock toggles every half period of 5 ns.
    always #5 clk_sys = ~clk_sys;

    dcmm_top #(.PWM_CYC(20), .CYC_PER_MS(10), .PLC_MIN_CYC(108)) dut (.clk_sys(clk_sys),
        .reset(reset), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq), .mon_raw(mon),
        .spd_route_q(spd_r), .pos_route_q(pos_r), .pwm_tick_q(pwm_t), .cur_tick_q(cur_t),
        .pos_tick_q(pos_t), .spd_tick_q(spd_t), .plc_tick_q(plc_t), .kv_scale_q(kv),
        .err_q(err));
    dcmm_drive_model model (.clk_sys(clk_sys), .fault_pat(pat), .mon_raw(mon));

    task automatic chk(input logic [39:0] s, input logic [39:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic wt(input int c);
        repeat (c) @(posedge clk_sys);
    endtask

    // One Avalon transfer, held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        @(posedge clk_sys);
        adr <= a;
        wd  <= d;
        be  <= b;
        rd  <= !w;
        wr  <= w;
        do begin
            @(posedge clk_sys);
        end while (wreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(q, e);
    endtask

    // Raise one pin pattern under one control setting, read the latch, clear and acknowledge.
    task automatic mon_case(input logic [49:0] p, input logic [31:0] c, input logic [31:0] e);
        bus(1'b1, 6'h00, c, 4'hF);
        pat <= p;
        wt(8);
        rchk(6'h20, e);
        chk(err.code, e[15:0]);
        pat <= 50'h0;
        wt(8);
        bus(1'b1, 6'h20, 32'h0100_0000, 4'h8);
    endtask

    // Measure the first full gap between PLC ticks after a new setting.
    task automatic plc(input logic [31:0] s, input int e);
        bus(1'b1, 6'h04, s, 4'hF);
        repeat (2) begin
            k = 0;
            do begin
                @(posedge clk_sys);
                k++;
            end while (plc_t !== 1'b1 && k < 700);
        end
        chk(k, e);
    endtask

    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // A hang ends the run as a failure.
    initial begin
        #200000;
        err_total++;
        close_out();
    end

    // Main sequence of tests.
    initial begin
        wt(20);
        reset <= 1'b0;
        rchk(6'h00, 32'h0);
        rchk(6'h0C, 32'h2C688);
        rchk(6'h10, 32'hE4);
        rchk(6'h24, 32'h3F0);
        rchk(6'h3C, 32'h0);
        chk(spd_r, 40'h9876543210);
        $display("reset test done");
        bus(1'b1, 6'h14, 32'h3F, 4'hF);
        bus(1'b1, 6'h18, 32'hF, 4'hF);
        bus(1'b1, 6'h08, 32'h100F_1211, 4'hF);
        wt(4);
        chk(spd_r, 40'h9876541032);
        bus(1'b1, 6'h08, 32'h0000_1100, 4'hF);
        mon_case(50'h0, 32'h000, 32'h0301_C2A0);
        bus(1'b1, 6'h08, 32'h0, 4'hF);
        bus(1'b1, 6'h20, 32'h0100_0000, 4'h8);
        wt(4);
        chk(spd_r, 40'h9876543210);
        $display("speed input test done");
        mon_case(50'h400_0000_0000, 32'h000, 32'h0302_0E01);
        mon_case(50'h400_0000_0000, 32'h010, 32'h0);
        mon_case(50'h2_0000_0000, 32'h000, 32'h0303_0E02);
        mon_case(50'h2_0000_0000, 32'h020, 32'h0);
        mon_case(50'h100_0000, 32'h000, 32'h0304_8860);
        mon_case(50'h100_0000, 32'h080, 32'h0);
        mon_case(50'h1_0000, 32'h000, 32'h0306_8870);
        $display("monitor test done");
        bus(1'b1, 6'h0C, 32'h468D, 4'hF);
        bus(1'b1, 6'h10, 32'h27, 4'hF);
        wt(4);
        chk(pos_r, 40'h6879043215);
        n = '{0, 0, 0, 0, 0};
        repeat (200) begin
            @(posedge clk_sys);
            n[0] += pwm_t;
            n[1] += pos_t;
            n[2] += cur_t;
            n[3] += spd_t[0];
            n[4] += spd_t[4];
        end
        chk(n[0], 10);
        chk(n[1], 10);
        chk(n[2], 20);
        chk(n[3], 10);
        chk(n[4], 20);
        plc(32'd5, 108);
        plc(32'd10, 108);
        plc(32'd11, 110);
        plc(32'd61, 600);
        $display("timing test done");
        bus(1'b1, 6'h1C, 32'h30, 4'hF);
        bus(1'b1, 6'h00, 32'h0, 4'hF);
        pat <= 50'h10;
        wt(40);
        chk(kv[39:32] < 8'h10, 1'b1);
        rchk(6'h24, 32'h0010_03F0);
        wt(5200);
        chk(kv[39:32], 8'hFF);
        bus(1'b1, 6'h00, 32'h100, 4'hF);
        pat <= 50'h30;
        wt(8);
        chk(kv[47:40], 8'hFF);
        pat <= 50'h0;
        wt(8);
        chk(kv[47:32], 16'h0);
        $display("gain ramp test done");
        close_out();
    end
endmodule
`default_nettype wire
